// ### timer_slave_cfg.svh
/*
  Constants of the timer slave-mode and request-gating block: register
  offsets, field positions, bit masks and reset values.
  Assumes it is included by bare name into the slave design file and the bench.
*/
// Overview of operation
// - Sync-start bit makes the selected trigger the counter start event in mode 000.
// - Source codes 000 to 011 pick internal triggers zero to three.
// - Codes 100, 101, 110 pick chan0 edge pulse, chan0, chan1 filtered.
// - Mode 000 without sync start: counter ticks every timer clock while run bit is set.
// - Restart mode: trigger rising edge reloads counter, makes update.
// - Pause mode: counter ticks only while the trigger is high.
// - Event mode: trigger rising edge starts the counter.
// - External clock mode: one count per trigger rising edge.
// - Enable bit 14 gates trigger DMA requests.
// - Bits 10 and 9 gate chan1 and chan0 DMA requests.
// - Bit 8 gates update DMA requests.
// - Bits 7, 6, 5 gate break, trigger, commutation interrupts.
// - Bits 2, 1, 0 gate chan1, chan0, update interrupts.
// - Flag register keeps over-capture flags at bits 10 and 9.
// - Over-capture sets on capture while channel flag is set.
// - Trigger flag sets on active edge outside mode 000, or both edges in pause mode.
// - Channel flag sets on capture or compare; capture read clears it.
`ifndef TIMER_SLAVE_CFG_SVH
`define TIMER_SLAVE_CFG_SVH
`define OFS_SMCFG    12'h008
`define OFS_DMAINT   12'h00c
`define OFS_FLAGS    12'h010
`define SMCFG_MASK   32'h0000_00f7
`define DMAINT_MASK  32'h0000_47e7
`define FLAGS_MASK   32'h0000_06e7
`define IRQ_MASK     32'h0000_00e7
`define RST_WORD     32'h0000_0000
`define B_SYNC       7
`define B_TSEL_HI    6
`define B_TSEL_LO    4
`define B_MODE_HI    2
`define B_MODE_LO    0
`define B_UP         0
`define B_CH0        1
`define B_CH1        2
`define B_CMT        5
`define B_TRG        6
`define B_BRK        7
`define B_UPD        8
`define B_CH0D       9
`define B_CH1D       10
`define B_TRGD       14
`define B_CH0O       9
`define B_CH1O       10
`define CNT_RST      16'h0000
`define CNT_ONE      16'h0001
`endif

// ### timer_slave.sv
/*
  Slave-mode controller, event flags and DMA/interrupt gating of a
  two-channel timer, reached over APB.
  Assumes channel, break and commutation events arrive as one-cycle
  pulses from logic on CLOCK; trigger inputs come from pins or other
  domains and are synchronised here.
*/
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`include "timer_slave_cfg.svh"

package timer_slave_pkg;
  typedef enum logic [2:0] {SM_OFF = 3'h0, SM_RESTART = 3'h4,
    SM_PAUSE = 3'h5, SM_EVENT = 3'h6, SM_EXTCLK = 3'h7} slave_mode_t;
  typedef enum logic [1:0] {RUN_STOPPED = 2'h1, RUN_ACTIVE = 2'h2} run_state_t;
endpackage

module timer_slave
(
  input  wire logic        CLOCK,          // Timer clock, 40 MHz.
  input  wire logic        SYS_RST,        // Synchronous reset, high.
  input  wire logic        PSEL,           // APB select.
  input  wire logic        PENABLE,        // APB access phase.
  input  wire logic        PWRITE,         // APB write.
  input  wire logic [11:0] PADDR,          // APB byte address.
  input  wire logic [31:0] PWDATA,         // APB write data.
  output logic      [31:0] PRDATA,         // APB read data.
  output logic             PREADY,         // APB ready.
  output logic             PSLVERR,        // APB error, unmapped.
  input  wire logic [3:0]  INTERNAL_TRIG,  // Internal triggers 0 to 3.
  input  wire logic        CHAN0_EDGE,     // Chan0 edge pulse level.
  input  wire logic        CHAN0_FILT,     // Chan0 filtered input.
  input  wire logic        CHAN1_FILT,     // Chan1 filtered input.
  input  wire logic        COUNTER_RUN,    // Counter run bit.
  input  wire logic [1:0]  CHAN_INPUT,     // Channel is in input mode.
  input  wire logic [1:0]  CHAN_EVENT,     // Capture/compare pulse.
  input  wire logic [1:0]  CAPT_READ,      // Capture value read pulse.
  input  wire logic        UPDATE_EVENT,   // Counter update pulse.
  input  wire logic        COMMUT_EVENT,   // Commutation pulse.
  input  wire logic        BREAK_EVENT,    // Break pulse.
  output logic             COUNT_TICK,     // Counter advance enable.
  output logic             COUNT_RELOAD,   // Counter reinitialise.
  output logic             COUNT_UPDATE,   // Update from restart.
  output logic             IRQ,            // Gated interrupt request.
  output logic      [3:0]  DMA_REQ         // trg, ch1, ch0, update.
);

  logic [31:0] slave_mode_config;
  logic [31:0] dma_irq_enable;
  logic [31:0] event_flags;
  logic [6:0]  sync1;
  logic [6:0]  sync2;
  logic        selected_trigger_in;
  logic        trig_prev;
  logic        trig_rise;
  logic        trig_fall;
  logic        trig_event;
  logic        bus_wr;
  logic        bus_rd;
  logic [31:0] wr_clear;
  logic [31:0] flag_set;
  timer_slave_pkg::slave_mode_t mode;
  timer_slave_pkg::run_state_t  run_state;
  logic        sync_start_enable;
  logic [2:0]  trigger_source_select;
  logic        start_armed;

  function automatic logic hit(input logic [11:0] ofs);
    hit = (PADDR == ofs);
  endfunction

  assign bus_wr = PSEL & PENABLE & PWRITE & PREADY;
  assign bus_rd = PSEL & ~PENABLE & ~PWRITE;
  assign sync_start_enable = slave_mode_config[`B_SYNC];
  assign trigger_source_select = slave_mode_config[`B_TSEL_HI:`B_TSEL_LO];
  assign mode = timer_slave_pkg::slave_mode_t'(
    slave_mode_config[`B_MODE_HI:`B_MODE_LO]);
  assign start_armed = (mode == timer_slave_pkg::SM_EVENT) |
    ((mode == timer_slave_pkg::SM_OFF) & sync_start_enable);

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // One wait-free access phase: the read word is latched in setup.
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= `RST_WORD;
    end
    else
    begin
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & ~(hit(`OFS_SMCFG) |
                 hit(`OFS_DMAINT) | hit(`OFS_FLAGS));
      if (bus_rd)
      begin
        if (hit(`OFS_SMCFG))
          PRDATA <= slave_mode_config;
        else if (hit(`OFS_DMAINT))
          PRDATA <= dma_irq_enable;
        else if (hit(`OFS_FLAGS))
          PRDATA <= event_flags;
        else
          PRDATA <= `RST_WORD;
      end
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
      slave_mode_config <= `RST_WORD;
    else if (bus_wr && hit(`OFS_SMCFG))
      slave_mode_config <= PWDATA & `SMCFG_MASK;
  end

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
      dma_irq_enable <= `RST_WORD;
    else if (bus_wr && hit(`OFS_DMAINT))
      dma_irq_enable <= PWDATA & `DMAINT_MASK;
  end

  // ---------------------------------------------------------------
  // Trigger selection
  // ---------------------------------------------------------------
  // Every trigger source may come from another domain, so all pass
  // two flops; this costs two cycles of trigger latency.
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      sync1 <= 7'h00;
      sync2 <= 7'h00;
    end
    else
    begin
      sync1 <= {CHAN1_FILT, CHAN0_FILT, CHAN0_EDGE, INTERNAL_TRIG};
      sync2 <= sync1;
    end
  end

  always_comb
  begin
    if (trigger_source_select[2] == 1'b0)
      selected_trigger_in = sync2[trigger_source_select[1:0]];
    else if (trigger_source_select == 3'h7)
      selected_trigger_in = 1'b0;
    else
      selected_trigger_in = sync2[4 + trigger_source_select[1:0]];
  end

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
      trig_prev <= 1'b0;
    else
      trig_prev <= selected_trigger_in;
  end

  assign trig_rise = selected_trigger_in & ~trig_prev;
  assign trig_fall = ~selected_trigger_in & trig_prev;
  assign trig_event = (mode == timer_slave_pkg::SM_PAUSE) ?
    (trig_rise | trig_fall) :
    (trig_rise & (mode != timer_slave_pkg::SM_OFF));

  // ---------------------------------------------------------------
  // Slave mode control
  // ---------------------------------------------------------------
  // Only event mode and sync start arm on the trigger; leaving them
  // disarms, so an edge seen in another mode never starts the counter.
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST || !COUNTER_RUN || !start_armed)
      run_state <= timer_slave_pkg::RUN_STOPPED;
    else if (trig_rise)
      run_state <= timer_slave_pkg::RUN_ACTIVE;
  end

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      COUNT_TICK   <= 1'b0;
      COUNT_RELOAD <= 1'b0;
      COUNT_UPDATE <= 1'b0;
    end
    else
    begin
      COUNT_RELOAD <= (mode == timer_slave_pkg::SM_RESTART) & trig_rise;
      COUNT_UPDATE <= (mode == timer_slave_pkg::SM_RESTART) & trig_rise;
      unique case (mode)
        timer_slave_pkg::SM_RESTART:
          COUNT_TICK <= COUNTER_RUN;
        timer_slave_pkg::SM_PAUSE:
          COUNT_TICK <= COUNTER_RUN & selected_trigger_in;
        timer_slave_pkg::SM_EVENT:
          COUNT_TICK <= (run_state == timer_slave_pkg::RUN_ACTIVE)
                        | (COUNTER_RUN & trig_rise);
        timer_slave_pkg::SM_EXTCLK:
          COUNT_TICK <= trig_rise;
        default:
          COUNT_TICK <= COUNTER_RUN & (!sync_start_enable ||
            run_state == timer_slave_pkg::RUN_ACTIVE);
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Event flags and request gating
  // ---------------------------------------------------------------
  always_comb
  begin
    flag_set = `RST_WORD;
    flag_set[`B_UP]   = UPDATE_EVENT |
      ((mode == timer_slave_pkg::SM_RESTART) & trig_rise);
    flag_set[`B_CH0]  = CHAN_EVENT[0];
    flag_set[`B_CH1]  = CHAN_EVENT[1];
    flag_set[`B_CMT]  = COMMUT_EVENT;
    flag_set[`B_TRG]  = trig_event;
    flag_set[`B_BRK]  = BREAK_EVENT;
    flag_set[`B_CH0O] = CHAN_EVENT[0] & CHAN_INPUT[0] &
                        event_flags[`B_CH0];
    flag_set[`B_CH1O] = CHAN_EVENT[1] & CHAN_INPUT[1] &
                        event_flags[`B_CH1];
    wr_clear = `RST_WORD;
    if (bus_wr && hit(`OFS_FLAGS))
      wr_clear = ~PWDATA;
    wr_clear[`B_CH0] = wr_clear[`B_CH0] | (CAPT_READ[0] & CHAN_INPUT[0]);
    wr_clear[`B_CH1] = wr_clear[`B_CH1] | (CAPT_READ[1] & CHAN_INPUT[1]);
  end

  // Writing zero clears a flag; a new event in that cycle still wins.
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
      event_flags <= `RST_WORD;
    else
      event_flags <= ((event_flags & ~wr_clear) | flag_set)
                     & `FLAGS_MASK;
  end

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      IRQ     <= 1'b0;
      DMA_REQ <= 4'h0;
    end
    else
    begin
      IRQ <= |(event_flags & dma_irq_enable & `IRQ_MASK);
      DMA_REQ[3] <= event_flags[`B_TRG] & dma_irq_enable[`B_TRGD];
      DMA_REQ[2] <= event_flags[`B_CH1] & dma_irq_enable[`B_CH1D];
      DMA_REQ[1] <= event_flags[`B_CH0] & dma_irq_enable[`B_CH0D];
      DMA_REQ[0] <= event_flags[`B_UP] & dma_irq_enable[`B_UPD];
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_irq_gate;
    @(posedge CLOCK) disable iff (SYS_RST)
    ##1 IRQ == |($past(event_flags) & $past(dma_irq_enable) & `IRQ_MASK);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt not gated by flag and enable");
  property p_trg_dma;
    @(posedge CLOCK) disable iff (SYS_RST)
    (event_flags[`B_TRG] && dma_irq_enable[`B_TRGD]) |=> DMA_REQ[3];
  endproperty
  a_trg_dma: assert property (p_trg_dma)
    else $error("trigger DMA request missing");
  property p_upd_dma;
    @(posedge CLOCK) disable iff (SYS_RST)
    !dma_irq_enable[`B_UPD] |=> !DMA_REQ[0];
  endproperty
  a_upd_dma: assert property (p_upd_dma)
    else $error("update DMA request not suppressed");
  property p_ch_dma;
    @(posedge CLOCK) disable iff (SYS_RST)
    (event_flags[`B_CH0] && dma_irq_enable[`B_CH0D]) |=> DMA_REQ[1];
  endproperty
  a_ch_dma: assert property (p_ch_dma)
    else $error("channel DMA request missing");
  property p_restart;
    @(posedge CLOCK) disable iff (SYS_RST)
    (mode == timer_slave_pkg::SM_RESTART && trig_rise)
      |=> COUNT_RELOAD && COUNT_UPDATE && event_flags[`B_UP];
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart did not reload counter");
  property p_pause;
    @(posedge CLOCK) disable iff (SYS_RST)
    (mode == timer_slave_pkg::SM_PAUSE && !selected_trigger_in)
      |=> !COUNT_TICK;
  endproperty
  a_pause: assert property (p_pause)
    else $error("counter ticked with pause trigger low");
  property p_extclk;
    @(posedge CLOCK) disable iff (SYS_RST)
    (mode == timer_slave_pkg::SM_EXTCLK) |=> COUNT_TICK == $past(trig_rise);
  endproperty
  a_extclk: assert property (p_extclk)
    else $error("external clock tick not on trigger edge");
  property p_trg_flag;
    @(posedge CLOCK) disable iff (SYS_RST)
    trig_event |=> event_flags[`B_TRG];
  endproperty
  a_trg_flag: assert property (p_trg_flag)
    else $error("trigger flag not set");
  property p_overcap;
    @(posedge CLOCK) disable iff (SYS_RST)
    (CHAN_EVENT[0] && CHAN_INPUT[0] && event_flags[`B_CH0])
      |=> event_flags[`B_CH0O];
  endproperty
  a_overcap: assert property (p_overcap)
    else $error("over-capture flag not set");
  property p_reserved;
    @(posedge CLOCK) disable iff (SYS_RST)
    ##1 (event_flags & ~`FLAGS_MASK) == 32'h0 &&
        (dma_irq_enable & ~`DMAINT_MASK) == 32'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit became set");
  c_restart: cover property (@(posedge CLOCK) disable iff (SYS_RST)
    mode == timer_slave_pkg::SM_RESTART && trig_rise);
  c_event_start: cover property (@(posedge CLOCK) disable iff (SYS_RST)
    mode == timer_slave_pkg::SM_EVENT && trig_rise ##1 COUNT_TICK);
  c_overcap: cover property (@(posedge CLOCK) disable iff (SYS_RST)
    $rose(event_flags[`B_CH1O]));
  c_irq: cover property (@(posedge CLOCK) disable iff (SYS_RST) $rose(IRQ));

endmodule // timer_slave

// ### timer_trig_partner.sv
/*
  Behavioural model of the trigger sources around the timer: other
  timers and the channel input filters.
  Assumes the bench asks for new levels on src_req after a clock edge.
*/
`timescale 1ns/10ps

module timer_trig_partner
#(
  parameter int LAT = 1
)
(
  input  wire logic       clock,      // Timer clock.
  input  wire logic       sys_rst,    // Synchronous reset, high.
  input  wire logic [6:0] src_req,    // Wanted source levels.
  output logic      [3:0] itrig,      // Internal triggers 0 to 3.
  output logic            chan0_edge, // Chan0 edge pulse level.
  output logic            chan0_filt, // Chan0 filtered input.
  output logic            chan1_filt  // Chan1 filtered input.
);
  // ----------------------------------------
  // Source delay line
  // ----------------------------------------
  // Other timers launch their trigger outputs from flops, so a change
  // shows LAT cycles late; a larger LAT models a slow neighbour.
  logic [6:0] pipe [LAT];

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      pipe <= '{default: '0};
    else
    begin
      pipe[0] <= src_req;
      for (int i = 1; i < LAT; i++)
        pipe[i] <= pipe[i-1];
    end
  end

  assign {chan1_filt, chan0_filt, chan0_edge, itrig} = pipe[LAT-1];
endmodule // timer_trig_partner

// ### tb_timer_slave_trigger_irq_ctrl.sv
/*
  Self-checking bench of the timer slave block: registers, trigger
  routing, slave modes, flags and request gating.
  Assumes timer_slave and timer_trig_partner are compiled first.
*/
`timescale 1ns/10ps
`include "timer_slave_cfg.svh"

module tb_timer_slave_trigger_irq_ctrl;
  logic clock = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, run = 1'b0, upd = 1'b0, cmt = 1'b0, brk = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat, en, fl;
  logic [6:0] srcs = 7'h00;
  logic [1:0] chin = 2'h0, chev = 2'h0, crd = 2'h0;
  logic [3:0] itrig, dma;
  logic pready, pslverr, e0, f0, f1, tick, rld, cupd, irq, rerr;
  int tick_cnt = 0, rld_cnt = 0, u_cnt = 0, error_cnt = 0;
  int checks_done = 0, t0, r0, u0, n;
  int seed = 32'h0365d9a3;
  int bitpos[6] = '{0, 1, 2, 5, 7, 6};

  timer_slave dut (.CLOCK(clock), .SYS_RST(sys_rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .INTERNAL_TRIG(itrig), .CHAN0_EDGE(e0), .CHAN0_FILT(f0),
    .CHAN1_FILT(f1), .COUNTER_RUN(run), .CHAN_INPUT(chin),
    .CHAN_EVENT(chev), .CAPT_READ(crd), .UPDATE_EVENT(upd),
    .COMMUT_EVENT(cmt), .BREAK_EVENT(brk), .COUNT_TICK(tick),
    .COUNT_RELOAD(rld), .COUNT_UPDATE(cupd), .IRQ(irq), .DMA_REQ(dma));

  timer_trig_partner #(.LAT(2)) far (.clock(clock), .sys_rst(sys_rst),
    .src_req(srcs), .itrig(itrig), .chan0_edge(e0), .chan0_filt(f0),
    .chan1_filt(f1));

  initial
  begin
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock)
  begin
    tick_cnt <= tick_cnt + int'(tick);
    rld_cnt <= rld_cnt + int'(rld);
    u_cnt <= u_cnt + int'(cupd);
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask

  // The mode goes off with the old source still in place, and only then
  // does the source change, so a running mode never sees it switched.
  task automatic cfg(input logic s, input logic [2:0] t, input logic [2:0] m);
    apb(1'b0, `OFS_SMCFG, 32'h0);
    wr(`OFS_SMCFG, rdat & 32'h0000_0070);
    wr(`OFS_SMCFG, {24'h0, s, t, 4'h0});
    wr(`OFS_SMCFG, {24'h0, s, t, 1'b0, m});
  endtask

  task automatic tk(input int k);
    cyc(8);
    t0 = tick_cnt;
    cyc(5);
    chk(32'(tick_cnt - t0), 32'(k));
  endtask

  function automatic logic [3:0] exp_dma(input logic [31:0] e, f);
    return {f[6] & e[14], f[2] & e[10], f[1] & e[9], f[0] & e[8]};
  endfunction

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    cyc(20000);
    error_cnt++;
    $display("ERROR at %0t: watchdog expired", $time);
    print_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    cyc(6);
    sys_rst <= 1'b0;
    rchk(`OFS_SMCFG, `RST_WORD);
    rchk(`OFS_DMAINT, `RST_WORD);
    rchk(`OFS_FLAGS, `RST_WORD);
    wr(`OFS_SMCFG, 32'hffff_ffff);
    rchk(`OFS_SMCFG, 32'h0000_00f7);
    wr(`OFS_DMAINT, 32'hffff_ffff);
    rchk(`OFS_DMAINT, 32'h0000_47e7);
    wr(`OFS_FLAGS, 32'hffff_ffff);
    rchk(`OFS_FLAGS, `RST_WORD);
    rchk(12'h014, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    run <= 1'b1;
    cfg(1'b0, 3'h0, 3'h0);
    tk(5);
    run <= 1'b0;
    tk(0);
    run <= 1'b1;
    cfg(1'b1, 3'h2, 3'h0);
    tk(0);
    srcs[2] <= 1'b1;
    tk(5);
    cfg(1'b0, 3'h5, 3'h5);
    tk(0);
    srcs[5] <= 1'b1;
    tk(5);
    srcs <= 7'h00;
    cfg(1'b0, 3'h3, 3'h6);
    tk(0);
    srcs[3] <= 1'b1;
    tk(5);
    cfg(1'b0, 3'h1, 3'h7);
    n = 3 + ($random(seed) & 3);
    // Ticks launched while the mode was briefly off must drain first.
    cyc(3);
    t0 = tick_cnt;
    repeat (n)
    begin
      srcs[1] <= 1'b1;
      cyc(4);
      srcs[1] <= 1'b0;
      cyc(4);
    end
    cyc(8);
    chk(32'(tick_cnt - t0), 32'(n));
    for (int k = 0; k < 7; k++)
    begin
      srcs <= 7'h00;
      cfg(1'b0, 3'(k), 3'h4);
      wr(`OFS_FLAGS, 32'h0);
      r0 = rld_cnt;
      u0 = u_cnt;
      srcs[(k + 1) % 7] <= 1'b1;
      cyc(8);
      chk(32'(rld_cnt - r0), 32'h0);
      srcs[k] <= 1'b1;
      cyc(8);
      chk(32'(rld_cnt - r0 + u_cnt - u0), 32'h2);
      rchk(`OFS_FLAGS, 32'h0000_0041);
    end
    cfg(1'b0, 3'h0, 3'h7);
    for (int i = 0; i < 18; i++)
    begin
      en = (i < 6) ? 32'hffff_ffff : (i < 12) ? 32'h0 : $random(seed);
      fl = 32'h1 << bitpos[i % 6];
      srcs <= 7'h00;
      wr(`OFS_DMAINT, en);
      wr(`OFS_FLAGS, 32'h0);
      case (i % 6)
        0: upd <= 1'b1;
        1: chev <= 2'b01;
        2: chev <= 2'b10;
        3: cmt <= 1'b1;
        4: brk <= 1'b1;
        default: srcs[0] <= 1'b1;
      endcase
      cyc(1);
      {upd, cmt, brk, chev} <= 5'h00;
      cyc(8);
      rchk(`OFS_FLAGS, fl);
      chk({31'h0, irq}, {31'h0, |(en & fl & 32'he7)});
      chk({28'h0, dma}, {28'h0, exp_dma(en, fl)});
    end
    chin <= 2'b11;
    wr(`OFS_FLAGS, 32'h0);
    repeat (2)
    begin
      chev <= 2'b11;
      cyc(1);
      chev <= 2'b00;
      cyc(2);
    end
    rchk(`OFS_FLAGS, 32'h0000_0606);
    crd <= 2'b11;
    cyc(1);
    crd <= 2'b00;
    cyc(2);
    rchk(`OFS_FLAGS, 32'h0000_0600);
    print_verdict();
  end
endmodule // tb_timer_slave_trigger_irq_ctrl
